// ### tgen_pkg.sv
package tgen_pkg;
  // index width and field positions shared by every position register
  localparam int unsigned POS_W = 13;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned HI_LSB = 16;
  // word offsets on the register bus
  localparam logic [15:0] OFS_F1_VS_LINE = 16'h008C;
  localparam logic [15:0] OFS_F1_VS_CYCLE = 16'h0090;
  localparam logic [15:0] OFS_F1_ACTIVE = 16'h0094;
  localparam logic [15:0] OFS_PULSE_BASE = 16'h0100;
  localparam logic [15:0] OFS_PULSE_LAST = 16'h013C;
  localparam logic [15:0] OFS_GLOBAL_OFS = 16'h0140;
  // implemented bits; the rest read zero and ignore writes
  localparam logic [31:0] FIELD_MASK = 32'h1FFF1FFF;
  // values after reset
  localparam logic [31:0] RST_ACTIVE = 32'h00000000;
  localparam logic [31:0] RST_PULSE = 32'h00000000;
  localparam logic [31:0] RST_GLOBAL_OFS = 32'h00000000;
  localparam logic [12:0] RST_POS = 13'h0000;
  // answer on an unmapped address
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

// ### timing_gen_f1.sv
`timescale 1ns/1ns
// Functional notes
// - field 1 vsync begins/ends on programmed lines
// - field 1 vsync begins/ends on programmed cycles
// - field 1 active area from height/width fields
// - frame pulse at programmed line and cycle
// - frame pulse lasts one cycle, except when a resync reloads the counter onto its position
// - sixteen frame pulses, registers 0x100 to 0x13C
// - global vertical delay shifts generated timing
// - global horizontal delay shifts generated timing
// - both delays combine into one offset
// - shift only with detector and generator enabled
module timing_gen_f1 #(
  parameter int unsigned NUM_PULSE = 16
) (
  input wire logic mclk,
  input wire logic rst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // frame geometry with blanking, in cycles and lines
  input wire logic [12:0] frame_hsize,
  input wire logic [12:0] frame_vsize,
  // interlaced operation: fields alternate each frame
  input wire logic interlaced,
  // field 1 vsync window, read-only copies on the bus
  input wire logic [31:0] f1_vs_line_src,
  input wire logic [31:0] f1_vs_cycle_src,
  // detector start of frame and build/enable state
  input wire logic det_sof,
  input wire logic detector_en,
  input wire logic generator_en,
  // timing outputs
  output logic field_id,
  output logic field1_vsync,
  output logic field1_active,
  output logic [NUM_PULSE-1:0] fsync_out
);

  // merge write data into a register under byte enables, reserved masked
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge_bytes = m & tgen_pkg::FIELD_MASK;
  endfunction

  // step back by an offset, wrapping inside a period
  function automatic logic [12:0] wrap_back(input logic [12:0] size,
                                            input logic [12:0] ofs);
    logic [13:0] d;
    d = {1'b0, size} - {1'b0, ofs};
    if (ofs == 13'h0000 || size == 13'h0000 || ofs > size) begin
      wrap_back = 13'h0000;
    end else begin
      wrap_back = d[12:0];
    end
  endfunction

  // register storage
  logic [31:0] active_ff;
  logic [31:0] gofs_ff;
  logic [31:0] pulse_ff [NUM_PULSE];
  logic [31:0] vs_line_ff;
  logic [31:0] vs_cycle_ff;
  logic [31:0] rdat_ff;
  logic ack_ff;

  // generator state
  logic [12:0] h_ff;
  logic [12:0] v_ff;
  logic field_ff;
  logic vs_ff;
  logic act_ff;
  logic [NUM_PULSE-1:0] fs_ff;

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire bus_wr = bus_req & wb_we_i;
  wire in_pulse = (wb_adr_i >= tgen_pkg::OFS_PULSE_BASE) &&
                  (wb_adr_i <= tgen_pkg::OFS_PULSE_LAST) &&
                  (wb_adr_i[1:0] == 2'b00);
  wire [3:0] pulse_idx = wb_adr_i[5:2];
  wire hit_active = wb_adr_i == tgen_pkg::OFS_F1_ACTIVE;
  wire hit_gofs = wb_adr_i == tgen_pkg::OFS_GLOBAL_OFS;

  // read mux, reserved bits forced low
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = tgen_pkg::UNMAPPED_DATA;
    if (in_pulse) begin
      rd_mux = pulse_ff[pulse_idx];
    end else begin
      case (wb_adr_i)
        tgen_pkg::OFS_F1_VS_LINE: rd_mux = vs_line_ff;
        tgen_pkg::OFS_F1_VS_CYCLE: rd_mux = vs_cycle_ff;
        tgen_pkg::OFS_F1_ACTIVE: rd_mux = active_ff;
        tgen_pkg::OFS_GLOBAL_OFS: rd_mux = gofs_ff;
        default: rd_mux = tgen_pkg::UNMAPPED_DATA;
      endcase
    end
  end
  wire [31:0] nxt_rdat = rd_mux & tgen_pkg::FIELD_MASK;

  // field decode of programmed positions
  wire [12:0] vs_bl = vs_line_ff[tgen_pkg::LO_LSB +: tgen_pkg::POS_W];
  wire [12:0] vs_el = vs_line_ff[tgen_pkg::HI_LSB +: tgen_pkg::POS_W];
  wire [12:0] vs_bc = vs_cycle_ff[tgen_pkg::LO_LSB +: tgen_pkg::POS_W];
  wire [12:0] vs_ec = vs_cycle_ff[tgen_pkg::HI_LSB +: tgen_pkg::POS_W];
  wire [12:0] act_w = active_ff[tgen_pkg::LO_LSB +: tgen_pkg::POS_W];
  wire [12:0] act_h = active_ff[tgen_pkg::HI_LSB +: tgen_pkg::POS_W];
  wire [12:0] dly_h = gofs_ff[tgen_pkg::LO_LSB +: tgen_pkg::POS_W];
  wire [12:0] dly_v = gofs_ff[tgen_pkg::HI_LSB +: tgen_pkg::POS_W];

  // raster counters; wrap at the frame size
  wire h_last = (h_ff + 13'h0001) >= frame_hsize;
  wire v_last = (v_ff + 13'h0001) >= frame_vsize;
  wire shift_en = detector_en & generator_en;
  wire resync = det_sof & shift_en;
  logic [12:0] nxt_h;
  logic [12:0] nxt_v;
  always_comb begin
    nxt_h = h_last ? 13'h0000 : h_ff + 13'h0001;
    nxt_v = h_last ? (v_last ? 13'h0000 : v_ff + 13'h0001) : v_ff;
    if (resync) begin
      // input frame start lands delay lines and cycles before our origin
      nxt_h = wrap_back(frame_hsize, dly_h);
      nxt_v = wrap_back(frame_vsize, dly_v);
    end
  end
  wire frame_end = h_last & v_last & ~resync;
  wire nxt_field = frame_end ? (interlaced & ~field_ff) : field_ff;

  // field 1 vsync: end position has priority over begin
  wire vs_hit_b = (v_ff == vs_bl) && (h_ff == vs_bc);
  wire vs_hit_e = (v_ff == vs_el) && (h_ff == vs_ec);
  wire nxt_vs = field_ff & (vs_hit_e ? 1'b0 : (vs_hit_b | vs_ff));

  // field 1 active area, blanking excluded
  wire nxt_act = field_ff && (v_ff < act_h) && (h_ff < act_w);

  // frame pulses: single cycle where line and cycle both match
  logic [NUM_PULSE-1:0] nxt_fs;
  always_comb begin
    for (int i = 0; i < NUM_PULSE; i++) begin
      nxt_fs[i] = (v_ff == pulse_ff[i][28:16]) &&
                  (h_ff == pulse_ff[i][12:0]);
    end
  end

  // bus handshake: ack one cycle after request, dropped the next
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rdat_ff <= tgen_pkg::UNMAPPED_DATA;
    end else begin
      ack_ff <= bus_req;
      rdat_ff <= bus_req ? nxt_rdat : rdat_ff;
    end
  end

  // writable registers with byte enables
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      active_ff <= tgen_pkg::RST_ACTIVE;
      gofs_ff <= tgen_pkg::RST_GLOBAL_OFS;
    end else begin
      if (bus_wr && hit_active) begin
        active_ff <= merge_bytes(active_ff, wb_dat_i, wb_sel_i);
      end
      if (bus_wr && hit_gofs) begin
        gofs_ff <= merge_bytes(gofs_ff, wb_dat_i, wb_sel_i);
      end
    end
  end

  // sixteen pulse position registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_PULSE; i++) begin
        pulse_ff[i] <= tgen_pkg::RST_PULSE;
      end
    end else if (bus_wr && in_pulse) begin
      pulse_ff[pulse_idx] <= merge_bytes(pulse_ff[pulse_idx],
                                         wb_dat_i, wb_sel_i);
    end
  end

  // read-only vsync window copies, reserved bits dropped
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vs_line_ff <= tgen_pkg::RST_PULSE;
      vs_cycle_ff <= tgen_pkg::RST_PULSE;
    end else begin
      vs_line_ff <= f1_vs_line_src & tgen_pkg::FIELD_MASK;
      vs_cycle_ff <= f1_vs_cycle_src & tgen_pkg::FIELD_MASK;
    end
  end

  // raster and output flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      h_ff <= tgen_pkg::RST_POS;
      v_ff <= tgen_pkg::RST_POS;
      field_ff <= 1'b0;
      vs_ff <= 1'b0;
      act_ff <= 1'b0;
      fs_ff <= '0;
    end else begin
      h_ff <= nxt_h;
      v_ff <= nxt_v;
      field_ff <= nxt_field;
      vs_ff <= nxt_vs;
      act_ff <= nxt_act;
      fs_ff <= nxt_fs;
    end
  end

  // outputs straight from flops
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign field_id = field_ff;
  assign field1_vsync = vs_ff;
  assign field1_active = act_ff;
  assign fsync_out = fs_ff;

  // checks
  a_ack_follows: assert property (@(posedge mclk) disable iff (rst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  a_ack_single: assert property (@(posedge mclk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)
    wb_ack_o |-> (wb_dat_o[31:29] == 3'h0 && wb_dat_o[15:13] == 3'h0))
    else $error("reserved read bits not zero");
  a_gofs_write: assert property (@(posedge mclk) disable iff (rst)
    (bus_wr && hit_gofs && wb_sel_i == 4'hF)
    |=> gofs_ff == ($past(wb_dat_i) & tgen_pkg::FIELD_MASK))
    else $error("delay register write did not land masked");
  a_pulse_pos: assert property (@(posedge mclk) disable iff (rst)
    (v_ff == pulse_ff[0][28:16] && h_ff == pulse_ff[0][12:0])
    |=> fsync_out[0])
    else $error("frame pulse missing at programmed position");
  a_pulse_quiet: assert property (@(posedge mclk) disable iff (rst)
    !(v_ff == pulse_ff[0][28:16] && h_ff == pulse_ff[0][12:0])
    |=> !fsync_out[0])
    else $error("frame pulse away from programmed position");
  // a resync one edge earlier may land the counter on the same spot again
  a_pulse_once: assert property (@(posedge mclk) disable iff (rst)
    (fsync_out[0] && frame_hsize > 13'h0001 && !$past(resync))
    |=> !fsync_out[0])
    else $error("frame pulse longer than one cycle");
  a_vs_begin: assert property (@(posedge mclk) disable iff (rst)
    (field_ff && vs_hit_b && !vs_hit_e) |=> field1_vsync)
    else $error("field 1 vsync did not begin");
  a_vs_end: assert property (@(posedge mclk) disable iff (rst)
    vs_hit_e |=> !field1_vsync)
    else $error("field 1 vsync did not end");
  // vsync of this block belongs to field 1 only
  a_vs_field1: assert property (@(posedge mclk) disable iff (rst)
    !field_ff |=> !field1_vsync)
    else $error("field 1 vsync high outside field 1");
  // compare against the size in force when the flag was decided
  a_active_area: assert property (@(posedge mclk) disable iff (rst)
    field1_active |-> ($past(field_ff) && $past(v_ff) < $past(act_h) &&
                       $past(h_ff) < $past(act_w)))
    else $error("field 1 active outside programmed area");
  a_active_inside: assert property (@(posedge mclk) disable iff (rst)
    (field_ff && v_ff < act_h && h_ff < act_w) |=> field1_active)
    else $error("field 1 active missing inside programmed area");
  a_delay_load: assert property (@(posedge mclk) disable iff (rst)
    resync |=> h_ff == wrap_back($past(frame_hsize), $past(dly_h)))
    else $error("horizontal delay not applied");
  a_delay_line: assert property (@(posedge mclk) disable iff (rst)
    resync |=> v_ff == wrap_back($past(frame_vsize), $past(dly_v)))
    else $error("vertical delay not applied");
  a_no_shift: assert property (@(posedge mclk) disable iff (rst)
    (det_sof && !shift_en && !h_last) |=> h_ff == $past(h_ff) + 13'h0001)
    else $error("shift applied while disabled");
  c_pulse_seen: cover property (@(posedge mclk) disable iff (rst)
    fsync_out[0]);
  c_vs_window: cover property (@(posedge mclk) disable iff (rst)
    $rose(field1_vsync) ##[1:300] $fell(field1_vsync));
  c_resync: cover property (@(posedge mclk) disable iff (rst)
    resync && dly_h != 13'h0000 && dly_v != 13'h0000);
  c_bus_write: cover property (@(posedge mclk) disable iff (rst)
    bus_wr && in_pulse);
  c_active_seen: cover property (@(posedge mclk) disable iff (rst)
    $rose(field1_active));

endmodule

// ### tgen_sink.sv
`timescale 1ns/1ns
// downstream sink: counts frame pulses it takes in
module tgen_sink (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] fsync_out,
  output logic [31:0] pulse_cnt
);
  // one count for each pulse line high at an edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) pulse_cnt <= 32'h00000000;
    else pulse_cnt <= pulse_cnt + 32'($countones(fsync_out));
  end
endmodule

// ### timing_gen_field1_fsync_delay_tb_top.sv
`timescale 1ns/1ns
module timing_gen_field1_fsync_delay_tb_top;
  localparam int HS = 12;
  localparam int VS = 8;
  // vsync window: lines 1..3, cycles 2..5, reserved bits set
  localparam logic [31:0] LSRC = 32'hE003E001;
  localparam logic [31:0] CSRC = 32'hE005E002;
  logic mclk, rst, cyc, stb, we, det_sof, det_en, gen_en, ack;
  logic fid, vs, av, e_vs, e_act, fld, chk_on;
  logic [15:0] adr, fs, e_fs, ra;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, pcnt, ref_cnt, seed;
  logic [31:0] sh [128]; // shadow of the writable registers
  logic [31:0] dl [4];
  int rh, rv, error_cnt, comparisons;
  timing_gen_f1 #(.NUM_PULSE(16)) i_dut (.mclk(mclk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .frame_hsize(13'(HS)), .frame_vsize(13'(VS)), .interlaced(1'b1),
    .f1_vs_line_src(LSRC), .f1_vs_cycle_src(CSRC), .det_sof(det_sof),
    .detector_en(det_en), .generator_en(gen_en), .field_id(fid),
    .field1_vsync(vs), .field1_active(av), .fsync_out(fs));
  tgen_sink i_sink (.mclk(mclk), .rst(rst), .fsync_out(fs),
    .pulse_cnt(pcnt));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // byte-lane merge of a write, reserved bits dropped
  function automatic logic [31:0] mg(logic [31:0] o, d, logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) o[b*8+:8] = d[b*8+:8];
    return o & tgen_pkg::FIELD_MASK;
  endfunction
  // expected pulse lines for a counter position
  function automatic logic [15:0] fsd(int v, int h);
    for (int k = 0; k < 16; k++)
      fsd[k] = (sh[64+k][28:16] == v) && (sh[64+k][12:0] == h);
  endfunction
  // counter load on a resync, zero when out of range
  function automatic int ld(int sz, int d);
    return (d == 0 || d > sz) ? 0 : sz - d;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one classic wishbone cycle, bounded wait for ack
  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    int i;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (ack === 1'b1) break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    // a missing ack counts as a mismatch and ends the run
    if (i == 20) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // write a writable register and track it in the shadow
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    wb(1'b1, a, s, d);
    sh[a[8:2]] = mg(sh[a[8:2]], d, s);
  endtask
  // let frames run with outputs checked every cycle
  task automatic run(input int n);
    logic [31:0] s0, e0;
    @(posedge mclk);
    chk_on = 1'b1;
    s0 = pcnt;
    e0 = ref_cnt;
    repeat (n) @(posedge mclk);
    chk(pcnt - s0, ref_cnt - e0);
    chk_on = 1'b0;
  endtask
  task automatic sof;
    @(posedge mclk);
    det_sof <= 1'b1;
    @(posedge mclk);
    det_sof <= 1'b0;
  endtask
  // reference counters and expected registered outputs
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rh <= 0;
      rv <= 0;
      fld <= 1'b0;
      e_vs <= 1'b0;
      e_act <= 1'b0;
      e_fs <= 16'h0000;
      ref_cnt <= 32'h00000000;
    end else begin
      ref_cnt <= ref_cnt + 32'($countones(e_fs));
      e_fs <= fsd(rv, rh);
      e_act <= fld && rv < sh[37][28:16] && rh < sh[37][12:0];
      // window lines 1..3, cycles 2..5; low whenever field 0 runs
      if (!fld || (rv == 3 && rh == 5)) e_vs <= 1'b0;
      else if (rv == 1 && rh == 2) e_vs <= 1'b1;
      if (det_sof && det_en && gen_en) begin
        rh <= ld(HS, int'(sh[80][12:0]));
        rv <= ld(VS, int'(sh[80][28:16]));
      end else begin
        rh <= (rh == HS - 1) ? 0 : rh + 1;
        if (rh == HS - 1) rv <= (rv == VS - 1) ? 0 : rv + 1;
        if (rh == HS - 1 && rv == VS - 1) fld <= ~fld;
      end
    end
  end
  always @(negedge mclk) begin
    if (chk_on) begin
      chk(32'({fid, vs, av}), 32'({fld, e_vs, e_act}));
      chk(32'(fs), 32'(e_fs));
    end
  end
  initial begin
    {cyc, stb, we, det_sof, chk_on} = 5'h00;
    {adr, sel, wdat} = 52'h0;
    {error_cnt, comparisons} = 64'h0;
    foreach (sh[i]) sh[i] = 32'h00000000;
    dl = '{32'h00020003, 32'h00000005, 32'h00090000, 32'h0001000C};
    seed = 32'h7AB3;
    det_en = 1'b1;
    gen_en = 1'b1;
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    // reset values, unmapped and misaligned places read zero
    foreach (dl[i]) begin
      wb(1'b0, (i < 2) ? 16'h0094 + 16'(i*172) : 16'h0140 + 16'(i*2-2),
        4'hF, 32'h00000000);
      chk(q, 32'h00000000);
    end
    // read-only vsync windows ignore writes
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 16'h008C + 16'(i*4), 4'hF, $random(seed));
      wb(1'b0, 16'h008C + 16'(i*4), 4'hF, 32'h00000000);
      chk(q, (i ? CSRC : LSRC) & tgen_pkg::FIELD_MASK);
    end
    // random full and partial writes to every writable register
    for (int i = 0; i < 18; i++) begin
      ra = (i < 16) ? 16'h0100 + 16'(i*4) : (i == 16) ? 16'h0094 : 16'h0140;
      wr(ra, $random(seed));
      wr(ra, $random(seed), 4'($random(seed)));
      wb(1'b0, ra, 4'hF, 32'h00000000);
      chk(q, sh[ra[8:2]]);
    end
    // pulse positions inside the frame, line in the upper field, cycle in the lower, reserved bits set
    for (int k = 0; k < 16; k++)
      wr(16'h0100 + 16'(k*4), {3'h7, 13'(k % VS), 3'h7, 13'(($random(seed)
        & 32'hFF) % HS)});
    wr(16'h0094, 32'h00050008);
    wr(16'h0140, 32'h00000000);
    run(2 * HS * VS + 9);
    // delays: both, horizontal only, out of range, full line
    foreach (dl[i]) begin
      wr(16'h0140, dl[i]);
      sof();
      run(HS * VS + 20);
    end
    // resync refused unless detector and generator both enabled
    det_en <= 1'b0;
    sof();
    run(HS * VS);
    det_en <= 1'b1;
    gen_en <= 1'b0;
    sof();
    run(HS * VS);
    wrap_up();
  end
endmodule
